// [hdl/pioex_pkg.sv]
// Purpose: constants and types for the port I/O instruction executor
// Assumes: APB slave, 32-bit data, pull-up and interrupt control register pairs share a word each
// Notes:   opcode codes are local, not the core's bit patterns
// Operation
// RULE_01: timer one test skips if enabled-off and set
// RULE_02: timer two test skips if enabled-off and set
// RULE_03: timer three test skips if enabled-off and set
// RULE_04: timer four test skips if enabled-off and set
// RULE_05: port zero pins load accumulator
// RULE_06: accumulator drives port zero latch
// RULE_07: port one pins load accumulator
// RULE_08: accumulator loads port one latch
// RULE_09: port two pins load accumulator
// RULE_10: accumulator loads port two latch
// RULE_11: port three pins load accumulator bits one, zero
// RULE_12: accumulator bits one, zero load port three
// RULE_13: port four pins load accumulator
// RULE_14: accumulator loads port four latch
// RULE_15: ports five, six transfer both ways
// RULE_16: set-all, clear and set on bit port
// RULE_17: bit test skips when selected bit zero
// RULE_18: pull-up registers transfer both ways
// RULE_19: one word, one cycle, carry untouched
// RULE_20: enabled timer test is a no-operation
package pioex_pkg;

  localparam int unsigned ADDR_W    = 8;
  localparam int unsigned DATA_W    = 32;
  localparam int unsigned ACC_W     = 4;
  localparam int unsigned OP_W      = 5;
  localparam int unsigned NTIMER    = 4;
  localparam int unsigned DPORT_W   = 8;

  localparam logic [7:0] OFS_CMD    = 8'h00;
  localparam logic [7:0] OFS_ACC    = 8'h04;
  localparam logic [7:0] OFS_YIDX   = 8'h08;
  localparam logic [7:0] OFS_IRQC   = 8'h0C;
  localparam logic [7:0] OFS_STAT   = 8'h10;
  localparam logic [7:0] OFS_PULL   = 8'h14;
  localparam logic [7:0] OFS_PORTD  = 8'h18;

  // interrupt control: first register in [3:0], second in [7:4]
  localparam int unsigned IRQC_T1_BIT   = 2;
  localparam int unsigned IRQC_T2_BIT   = 3;
  localparam int unsigned IRQC_T3_BIT   = 4;
  localparam int unsigned IRQC_T4_BIT   = 5;
  localparam int unsigned STAT_SKIP_BIT = 0;
  localparam int unsigned STAT_FLAG_LSB = 1;
  localparam int unsigned PULL_ONE_LSB  = 4;

  localparam logic [3:0] ACC_RST    = 4'h0;
  localparam logic [3:0] YIDX_RST   = 4'h0;
  localparam logic [7:0] IRQC_RST   = 8'h00;
  localparam logic [3:0] PULL_RST   = 4'h0;
  localparam logic [7:0] PORTD_RST  = 8'h00;

  typedef struct packed {
    logic [3:0] p6;
    logic [3:0] p5;
    logic [3:0] p4;
    logic [1:0] p3;
    logic [2:0] p2;
    logic [3:0] p1;
    logic [3:0] p0;
  } pioex_pins_t;

  localparam pioex_pins_t PORT_RST = '0;

  typedef enum logic [4:0] {
    OP_IN_P0   = 5'h00, OP_IN_P1   = 5'h01, OP_IN_P2   = 5'h02,
    OP_IN_P3   = 5'h03, OP_IN_P4   = 5'h04, OP_IN_P5   = 5'h05,
    OP_IN_P6   = 5'h06, OP_OUT_P0  = 5'h08, OP_OUT_P1  = 5'h09,
    OP_OUT_P2  = 5'h0A, OP_OUT_P3  = 5'h0B, OP_OUT_P4  = 5'h0C,
    OP_OUT_P5  = 5'h0D, OP_OUT_P6  = 5'h0E, OP_SKIP_T1 = 5'h10,
    OP_SKIP_T2 = 5'h11, OP_SKIP_T3 = 5'h12, OP_SKIP_T4 = 5'h13,
    OP_SET_ALL = 5'h14, OP_CLR_BIT = 5'h15, OP_SET_BIT = 5'h16,
    OP_TST_BIT = 5'h17, OP_RD_PU0  = 5'h18, OP_WR_PU0  = 5'h19,
    OP_RD_PU1  = 5'h1A, OP_WR_PU1  = 5'h1B
  } pioex_op_t;

endpackage : pioex_pkg

// [hdl/pioex_bitport.sv]
// Purpose: single-bit output port with indexed set, clear and test
// Assumes: one operation strobe at most per cycle
// Notes:   an index beyond the port width changes nothing, tests as 1
`timescale 1ns/1ps
module pioex_bitport #(
  parameter int unsigned BITS = 8
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              resetn,
  // operation strobes
  input  wire logic              set_all,
  input  wire logic              clr_bit,
  input  wire logic              set_bit,
  input  wire logic [3:0]        sel,
  // port state
  output logic      [BITS-1:0]   d,
  output logic                   sel_val
);
  localparam int unsigned IW = $clog2(BITS);

  logic sel_ok;
  assign sel_ok  = (sel < BITS);
  assign sel_val = sel_ok ? d[sel[IW-1:0]] : 1'b1;

  for (genvar i = 0; i < BITS; i++) begin : g_bit
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        d[i] <= 1'b0;
      end else if (set_all) begin
        d[i] <= 1'b1;                                // [RULE_16]
      end else if (sel == 4'(i)) begin
        if (clr_bit) begin
          d[i] <= 1'b0;                              // [RULE_16]
        end else if (set_bit) begin
          d[i] <= 1'b1;                              // [RULE_16]
        end
      end
    end
  end

  property p_set_all;
    @(posedge clk) disable iff (!resetn)
      set_all |=> (d == {BITS{1'b1}});
  endproperty
  a_set_all: assert property (p_set_all)            // [RULE_16]
    else $error("set-all left a bit clear");

  property p_clr_only_sel;
    @(posedge clk) disable iff (!resetn)
      (clr_bit && !set_all && sel_ok) |=>
        !d[$past(sel[IW-1:0])] &&
        ((d | (BITS'(1) << $past(sel[IW-1:0]))) ==
         ($past(d) | (BITS'(1) << $past(sel[IW-1:0]))));
  endproperty
  a_clr_only_sel: assert property (p_clr_only_sel)  // [RULE_16]
    else $error("clear touched wrong bit");

  c_clr_bit: cover property (@(posedge clk) clr_bit && sel_ok);
endmodule : pioex_bitport

// [hdl/pioex_top.sv]
// Purpose: executes the port I/O instruction group for a 4-bit core
// Assumes: instructions arrive as APB writes to the command register
// Notes:   each accepted command completes in the cycle it is taken
//
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/1ps
module pioex_top (
  // clock and reset
  input  wire logic                         CLK,
  input  wire logic                         RESETN,
  // apb slave
  input  wire logic                         PSEL,
  input  wire logic                         PENABLE,
  input  wire logic                         PWRITE,
  input  wire logic [7:0]                   PADDR,
  input  wire logic [31:0]                  PWDATA,
  output logic      [31:0]                  PRDATA,
  output logic                              PREADY,
  output logic                              PSLVERR,
  // port pins
  input  wire pioex_pkg::pioex_pins_t       PIN_IN,
  output pioex_pkg::pioex_pins_t            PORT_OUT,
  output logic      [7:0]                   PORTD_OUT,
  output logic      [3:0]                   PULLUP_ZERO,
  output logic      [3:0]                   PULLUP_ONE,
  // core sequencer
  input  wire logic [3:0]                   TIMER_EVT,
  output logic                              SKIP_NEXT
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);

  logic [3:0]              acc_q;
  logic [3:0]              acc_nxt;
  logic [3:0]              yidx_r;
  logic [7:0]              irqc_r;
  logic [3:0]              flag_r;
  logic [3:0]              ien;
  logic [3:0]              clr_flag;
  logic [3:0]              pu0_r, pu0_nxt;
  logic [3:0]              pu1_r, pu1_nxt;
  logic                    skip_r, skip_nxt, last_skip_r;
  pioex_pkg::pioex_pins_t  port_r, port_nxt;
  pioex_pkg::pioex_op_t    op;
  logic                    op_legal;
  logic                    op_set_all, op_clr_bit, op_set_bit;
  logic [1:0]              tidx;
  logic [7:0]              d_q;
  logic                    d_sel;
  logic                    addr_ok, access, wr, exec;
  logic [31:0]             rdata_nxt, rdata_r;

  // apb decode; zero wait states
  always_comb begin
    unique case (PADDR)
      pioex_pkg::OFS_CMD, pioex_pkg::OFS_ACC, pioex_pkg::OFS_YIDX,
      pioex_pkg::OFS_IRQC, pioex_pkg::OFS_STAT, pioex_pkg::OFS_PULL,
      pioex_pkg::OFS_PORTD: addr_ok = 1'b1;
      default:              addr_ok = 1'b0;
    endcase
  end

  assign access  = PSEL && PENABLE;
  assign wr      = access && PWRITE && addr_ok;
  assign PREADY  = 1'b1;
  assign PSLVERR = access && !addr_ok;
  assign op      = pioex_pkg::pioex_op_t'(PWDATA[4:0]);
  assign tidx    = PWDATA[1:0];
  assign exec    = wr && (PADDR == pioex_pkg::OFS_CMD) && op_legal;

  assign ien = {irqc_r[pioex_pkg::IRQC_T4_BIT],
                irqc_r[pioex_pkg::IRQC_T3_BIT],
                irqc_r[pioex_pkg::IRQC_T2_BIT],
                irqc_r[pioex_pkg::IRQC_T1_BIT]};

  // instruction effects; carry is not touched by any of them [RULE_19]
  always_comb begin
    acc_nxt    = acc_q;
    port_nxt   = port_r;
    pu0_nxt    = pu0_r;
    pu1_nxt    = pu1_r;
    skip_nxt   = 1'b0;
    clr_flag   = 4'h0;
    op_legal   = 1'b1;
    op_set_all = 1'b0;
    op_clr_bit = 1'b0;
    op_set_bit = 1'b0;
    unique case (op)
      pioex_pkg::OP_IN_P0:  acc_nxt = PIN_IN.p0;              // [RULE_05]
      pioex_pkg::OP_OUT_P0: port_nxt.p0 = acc_q;              // [RULE_06]
      pioex_pkg::OP_IN_P1:  acc_nxt = PIN_IN.p1;              // [RULE_07]
      pioex_pkg::OP_OUT_P1: port_nxt.p1 = acc_q;              // [RULE_08]
      pioex_pkg::OP_IN_P2:  acc_nxt = {1'b0, PIN_IN.p2};      // [RULE_09]
      pioex_pkg::OP_OUT_P2: port_nxt.p2 = acc_q[2:0];         // [RULE_10]
      pioex_pkg::OP_IN_P3:  acc_nxt[1:0] = PIN_IN.p3;         // [RULE_11]
      pioex_pkg::OP_OUT_P3: port_nxt.p3 = acc_q[1:0];         // [RULE_12]
      pioex_pkg::OP_IN_P4:  acc_nxt = PIN_IN.p4;              // [RULE_13]
      pioex_pkg::OP_OUT_P4: port_nxt.p4 = acc_q;              // [RULE_14]
      pioex_pkg::OP_IN_P5:  acc_nxt = PIN_IN.p5;              // [RULE_15]
      pioex_pkg::OP_OUT_P5: port_nxt.p5 = acc_q;              // [RULE_15]
      pioex_pkg::OP_IN_P6:  acc_nxt = PIN_IN.p6;              // [RULE_15]
      pioex_pkg::OP_OUT_P6: port_nxt.p6 = acc_q;              // [RULE_15]
      pioex_pkg::OP_SKIP_T1, pioex_pkg::OP_SKIP_T2,
      pioex_pkg::OP_SKIP_T3, pioex_pkg::OP_SKIP_T4: begin
        // enabled timer: neither skip nor clear [RULE_20]
        skip_nxt       = !ien[tidx] && flag_r[tidx]; // [RULE_01] [RULE_02]
        clr_flag[tidx] = skip_nxt;                   // [RULE_03] [RULE_04]
      end
      pioex_pkg::OP_SET_ALL: op_set_all = 1'b1;               // [RULE_16]
      pioex_pkg::OP_CLR_BIT: op_clr_bit = 1'b1;               // [RULE_16]
      pioex_pkg::OP_SET_BIT: op_set_bit = 1'b1;               // [RULE_16]
      pioex_pkg::OP_TST_BIT: skip_nxt = !d_sel;               // [RULE_17]
      pioex_pkg::OP_RD_PU0:  acc_nxt = pu0_r;                 // [RULE_18]
      pioex_pkg::OP_WR_PU0:  pu0_nxt = acc_q;                 // [RULE_18]
      pioex_pkg::OP_RD_PU1:  acc_nxt = pu1_r;                 // [RULE_18]
      pioex_pkg::OP_WR_PU1:  pu1_nxt = acc_q;                 // [RULE_18]
      default:               op_legal = 1'b0;
    endcase
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      acc_q <= pioex_pkg::ACC_RST;
    end else if (exec) begin
      acc_q <= acc_nxt;                                       // [RULE_19]
    end else if (wr && PADDR == pioex_pkg::OFS_ACC) begin
      acc_q <= PWDATA[3:0];
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      yidx_r <= pioex_pkg::YIDX_RST;
      irqc_r <= pioex_pkg::IRQC_RST;
    end else if (wr && PADDR == pioex_pkg::OFS_YIDX) begin
      yidx_r <= PWDATA[3:0];
    end else if (wr && PADDR == pioex_pkg::OFS_IRQC) begin
      irqc_r <= PWDATA[7:0];
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      port_r <= pioex_pkg::PORT_RST;
      pu0_r  <= pioex_pkg::PULL_RST;
      pu1_r  <= pioex_pkg::PULL_RST;
    end else if (exec) begin
      port_r <= port_nxt;
      pu0_r  <= pu0_nxt;
      pu1_r  <= pu1_nxt;
    end
  end

  // skip is a one-cycle pulse to the sequencer; status keeps the skip result of the last command
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      skip_r      <= 1'b0;
      last_skip_r <= 1'b0;
    end else begin
      skip_r <= exec && skip_nxt;
      if (exec) begin
        last_skip_r <= skip_nxt;
      end
    end
  end

  // timer event wins over a clear in the same cycle, so none is lost
  for (genvar i = 0; i < 4; i++) begin : g_flag
    always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
        flag_r[i] <= 1'b0;
      end else if (TIMER_EVT[i]) begin
        flag_r[i] <= 1'b1;
      end else if (exec && clr_flag[i]) begin
        flag_r[i] <= 1'b0;                   // [RULE_01] [RULE_02] [RULE_03]
      end
    end
  end

  pioex_bitport #(
    .BITS    (pioex_pkg::DPORT_W)
  ) u_bitport (
    .clk     (CLK),
    .resetn  (RESETN),
    .set_all (exec && op_set_all),
    .clr_bit (exec && op_clr_bit),
    .set_bit (exec && op_set_bit),
    .sel     (yidx_r),
    .d       (d_q),
    .sel_val (d_sel)
  );

  // read data is captured in the setup phase so it comes from a flop
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    unique case (PADDR)
      pioex_pkg::OFS_ACC:   rdata_nxt[3:0] = acc_q;
      pioex_pkg::OFS_YIDX:  rdata_nxt[3:0] = yidx_r;
      pioex_pkg::OFS_IRQC:  rdata_nxt[7:0] = irqc_r;
      pioex_pkg::OFS_STAT: begin
        rdata_nxt[pioex_pkg::STAT_SKIP_BIT] = last_skip_r;
        rdata_nxt[pioex_pkg::STAT_FLAG_LSB +: 4] = flag_r;
      end
      pioex_pkg::OFS_PULL:  rdata_nxt[7:0] = {pu1_r, pu0_r};
      pioex_pkg::OFS_PORTD: rdata_nxt[7:0] = d_q;
      default:              rdata_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rdata_r <= 32'h0000_0000;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      rdata_r <= rdata_nxt;
    end
  end

  assign PRDATA      = rdata_r;
  assign PORT_OUT    = port_r;
  assign PORTD_OUT   = d_q;
  assign PULLUP_ZERO = pu0_r;
  assign PULLUP_ONE  = pu1_r;
  assign SKIP_NEXT   = skip_r;

  property p_t1_skip;
    (exec && op == pioex_pkg::OP_SKIP_T1 && !ien[0] && flag_r[0] &&
     !TIMER_EVT[0]) |=> (SKIP_NEXT && !flag_r[0]);
  endproperty
  a_t1_skip: assert property (p_t1_skip)           // [RULE_01]
    else $error("timer one test did not skip and clear");

  property p_t3_noskip;
    (exec && op == pioex_pkg::OP_SKIP_T3 && !flag_r[2]) ##1 1'b1
      |-> !SKIP_NEXT;
  endproperty
  a_t3_noskip: assert property (p_t3_noskip)       // [RULE_03]
    else $error("timer three test skipped on clear flag");

  property p_t2_enabled_nop;
    (exec && op == pioex_pkg::OP_SKIP_T2 && ien[1]) |=>
      !SKIP_NEXT && (flag_r[1] == $past(flag_r[1]) || $past(TIMER_EVT[1]));
  endproperty
  a_t2_enabled_nop: assert property (p_t2_enabled_nop) // [RULE_20]
    else $error("enabled timer two test acted");

  property p_in_p0;
    (exec && op == pioex_pkg::OP_IN_P0) |=> acc_q == $past(PIN_IN.p0);
  endproperty
  a_in_p0: assert property (p_in_p0)               // [RULE_05]
    else $error("port zero read wrong");

  property p_out_p0;
    (exec && op == pioex_pkg::OP_OUT_P0) |=>
      PORT_OUT.p0 == $past(acc_q);
  endproperty
  a_out_p0: assert property (p_out_p0)             // [RULE_06]
    else $error("port zero latch wrong");

  property p_in_p3;
    (exec && op == pioex_pkg::OP_IN_P3) |=>
      acc_q[1:0] == $past(PIN_IN.p3) && acc_q[3:2] == $past(acc_q[3:2]);
  endproperty
  a_in_p3: assert property (p_in_p3)               // [RULE_11]
    else $error("port three read wrong");

  property p_bit_test;
    (exec && op == pioex_pkg::OP_TST_BIT && yidx_r < 4'h8) |=>
      SKIP_NEXT == !$past(d_q[yidx_r[2:0]]);
  endproperty
  a_bit_test: assert property (p_bit_test)         // [RULE_17]
    else $error("bit test skip wrong");

  property p_wr_pu0;
    (exec && op == pioex_pkg::OP_WR_PU0) |=> PULLUP_ZERO == $past(acc_q);
  endproperty
  a_wr_pu0: assert property (p_wr_pu0)             // [RULE_18]
    else $error("pull-up zero write wrong");

  property p_one_cycle;
    SKIP_NEXT |-> $past(exec) && !$past(SKIP_NEXT);
  endproperty
  a_one_cycle: assert property (p_one_cycle)       // [RULE_19]
    else $error("skip without a command the cycle before");

  property p_t4_skip;
    (exec && op == pioex_pkg::OP_SKIP_T4 && !ien[3] && flag_r[3] &&
     !TIMER_EVT[3]) |=> (SKIP_NEXT && !flag_r[3]);
  endproperty
  a_t4_skip: assert property (p_t4_skip)           // [RULE_04]
    else $error("timer four test did not skip and clear");

  property p_in_p2;
    (exec && op == pioex_pkg::OP_IN_P2) |=>
      acc_q == {1'b0, $past(PIN_IN.p2)};
  endproperty
  a_in_p2: assert property (p_in_p2)               // [RULE_09]
    else $error("port two read wrong");

  property p_out_p3;
    (exec && op == pioex_pkg::OP_OUT_P3) |=>
      PORT_OUT.p3 == $past(acc_q[1:0]);
  endproperty
  a_out_p3: assert property (p_out_p3)             // [RULE_12]
    else $error("port three latch wrong");

  property p_rd_pu1;
    (exec && op == pioex_pkg::OP_RD_PU1) |=> acc_q == $past(PULLUP_ONE);
  endproperty
  a_rd_pu1: assert property (p_rd_pu1)             // [RULE_18]
    else $error("pull-up one read wrong");

  c_t1_skip:  cover property (exec && op == pioex_pkg::OP_SKIP_T1 ##1
                              SKIP_NEXT);
  c_evt_clr:  cover property (exec && |clr_flag && |TIMER_EVT);
  c_bit_skip: cover property (exec && op == pioex_pkg::OP_TST_BIT ##1
                              SKIP_NEXT);
endmodule : pioex_top

// [test/pioex_pin_model.sv]
// Purpose: far side of the executor: port pin levels and timer events
// Assumes: pins are always driven, so no released or floating state
// Notes:   timer events are registered, one cycle per request bit
`timescale 1ns/1ps
module pioex_pin_model (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   resetn,
  // requests from the bench
  input  wire pioex_pkg::pioex_pins_t lv,
  input  wire logic [3:0]             evt_req,
  // toward the design
  output pioex_pkg::pioex_pins_t      pin_in,
  output logic      [3:0]             timer_evt
);
  assign pin_in = lv;

  // registered so a pulse never straddles the bench's own edge
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      timer_evt <= 4'h0;
    end else begin
      timer_evt <= evt_req;
    end
  end
endmodule : pioex_pin_model

// [test/port_io_instruction_exec_bench.sv]
// Purpose: self-checking bench for the port I/O instruction executor
// Assumes: zero wait-state APB slave, commands through the CMD register
// Notes:   expected read values are queued by the driver, checked by a watcher
`timescale 1ns/1ps
module port_io_instruction_exec_bench;
  logic                   CLK = 1'b0;
  logic                   RESETN = 1'b0;
  logic                   PSEL = 1'b0;
  logic                   PENABLE = 1'b0;
  logic                   PWRITE = 1'b0;
  logic [7:0]             PADDR = 8'h00;
  logic [31:0]            PWDATA = 32'h0;
  logic [31:0]            PRDATA;
  logic                   PREADY;
  logic                   PSLVERR;
  logic                   SKIP_NEXT;
  pioex_pkg::pioex_pins_t lv = '0;
  pioex_pkg::pioex_pins_t pins;
  pioex_pkg::pioex_pins_t port_out;
  pioex_pkg::pioex_pins_t exp_port = '0;
  logic [7:0]             portd;
  logic [3:0]             pu0_o;
  logic [3:0]             pu1_o;
  logic [3:0]             evt_req = 4'h0;
  logic [3:0]             tevt;
  logic [31:0]            q[$];
  int                     n_mismatch = 0;
  int                     n_compared = 0;
  int                     n_skip = 0;

  always #20 CLK = ~CLK;

  pioex_pin_model u_pins (.clk(CLK), .resetn(RESETN), .lv(lv),
    .evt_req(evt_req), .pin_in(pins), .timer_evt(tevt));

  pioex_top u_dut (.CLK(CLK), .RESETN(RESETN), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .PIN_IN(pins),
    .PORT_OUT(port_out), .PORTD_OUT(portd), .PULLUP_ZERO(pu0_o),
    .PULLUP_ONE(pu1_o), .TIMER_EVT(tevt), .SKIP_NEXT(SKIP_NEXT));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic final_report;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report

  // request held until pready is seen with psel and penable
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 50);
    if (n >= 50) n_mismatch++;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd

  task automatic cmd(input logic [4:0] op);
    wr(pioex_pkg::OFS_CMD, {27'h0, op});
  endtask : cmd

  always @(posedge CLK) begin
    if (SKIP_NEXT === 1'b1) n_skip++;
    if (PSEL && PENABLE && !PWRITE && PREADY === 1'b1) begin
      if (PADDR == 8'h1C) chk({31'h0, PSLVERR}, 32'h1);
      chk(PRDATA, q.pop_front());
    end
  end

  initial begin
    repeat (20000) @(posedge CLK);
    n_mismatch++;
    final_report;
  end

  initial begin
    int k;
    int eb;
    logic [3:0] a;
    logic [7:0] expd;
    logic [3:0] pu [2];
    void'($urandom(32'h66C0));
    pu[0] = 4'h0;
    pu[1] = 4'h0;
    repeat (20) @(posedge CLK);
    RESETN <= 1'b1;
    for (k = 1; k < 7; k++) rd(8'(4 * k), 32'h0);
    $display("test reset done");
    for (k = 0; k < 7; k++) begin
      a = 4'($urandom);
      lv <= pioex_pkg::pioex_pins_t'(25'($urandom));
      wr(pioex_pkg::OFS_ACC, {28'h0, a});
      cmd(5'(k));
      case (k)
        0: rd(pioex_pkg::OFS_ACC, {28'h0, lv.p0});
        1: rd(pioex_pkg::OFS_ACC, {28'h0, lv.p1});
        2: rd(pioex_pkg::OFS_ACC, {28'h0, 1'b0, lv.p2});
        3: rd(pioex_pkg::OFS_ACC, {28'h0, a[3:2], lv.p3});
        4: rd(pioex_pkg::OFS_ACC, {28'h0, lv.p4});
        5: rd(pioex_pkg::OFS_ACC, {28'h0, lv.p5});
        default: rd(pioex_pkg::OFS_ACC, {28'h0, lv.p6});
      endcase
      a = 4'($urandom);
      wr(pioex_pkg::OFS_ACC, {28'h0, a});
      cmd(5'(k + 8));
      case (k)
        0: exp_port.p0 = a;
        1: exp_port.p1 = a;
        2: exp_port.p2 = a[2:0];
        3: exp_port.p3 = a[1:0];
        4: exp_port.p4 = a;
        5: exp_port.p5 = a;
        default: exp_port.p6 = a;
      endcase
      @(posedge CLK);
      case (k)
        0: chk({7'h0, port_out}, {7'h0, exp_port});
        1: chk({7'h0, port_out}, {7'h0, exp_port});
        2: chk({7'h0, port_out}, {7'h0, exp_port});
        3: chk({7'h0, port_out}, {7'h0, exp_port});
        4: chk({7'h0, port_out}, {7'h0, exp_port});
        default: chk({7'h0, port_out}, {7'h0, exp_port});
      endcase
    end
    $display("test ports done");
    for (k = 0; k < 4; k++) begin
      eb = (k < 2) ? 2 + k : 4 + (k - 2);
      evt_req <= 4'(1 << k);
      @(posedge CLK);
      evt_req <= 4'h0;
      wr(pioex_pkg::OFS_IRQC, 32'(1 << eb));
      cmd(5'(16 + k));
      rd(pioex_pkg::OFS_STAT, 32'(1 << (k + 1)));
      wr(pioex_pkg::OFS_IRQC, 32'(8'hFF ^ 8'(1 << eb)));
      cmd(5'(16 + k));
      rd(pioex_pkg::OFS_STAT, 32'h1);
      cmd(5'(16 + k));
      rd(pioex_pkg::OFS_STAT, 32'h0);
    end
    $display("test timers done");
    cmd(5'h14);
    rd(pioex_pkg::OFS_PORTD, 32'hFF);
    for (k = 0; k < 9; k++) begin
      expd = (k < 8) ? 8'hFF ^ 8'(1 << k) : 8'hFF;
      wr(pioex_pkg::OFS_YIDX, 32'(k));
      cmd(5'h15);
      rd(pioex_pkg::OFS_PORTD, {24'h0, expd});
      cmd(5'h17);
      rd(pioex_pkg::OFS_STAT, (k < 8) ? 32'h1 : 32'h0);
      cmd(5'h16);
      cmd(5'h17);
      rd(pioex_pkg::OFS_STAT, 32'h0);
      chk({24'h0, portd}, 32'hFF);
    end
    $display("test bit port done");
    for (k = 0; k < 2; k++) begin
      a = 4'($urandom);
      pu[k] = a;
      wr(pioex_pkg::OFS_ACC, {28'h0, a});
      cmd(5'(25 + 2 * k));
      wr(pioex_pkg::OFS_ACC, {28'h0, ~a});
      cmd(5'(24 + 2 * k));
      rd(pioex_pkg::OFS_ACC, {28'h0, a});
      rd(pioex_pkg::OFS_PULL, {24'h0, pu[1], pu[0]});
      chk({24'h0, pu1_o, pu0_o}, {24'h0, pu[1], pu[0]});
    end
    $display("test pull-up done");
    rd(8'h1C, 32'h0);
    repeat (3) @(posedge CLK);
    chk(32'(n_skip), 32'h0000_000C);
    $display("test unmapped and skip count done");
    final_report;
  end
endmodule : port_io_instruction_exec_bench
